// ---- design/cak_consts.svh ----
// Constants of the card authentication and key sequencer.
// Assumes inclusion by bare name from the design directory.
`ifndef CAK_CONSTS_SVH
`define CAK_CONSTS_SVH

// Host command codes
`define CAK_CMD_FIFO_KEY_LOAD 8'h19
`define CAK_CMD_AUTH_ONE 8'h0C
`define CAK_CMD_AUTH_TWO 8'h14

// Key buffer and FIFO key format
`define CAK_KEY_BITS 48
`define CAK_KEY_BYTES 7'h0C
`define CAK_KEY_LAST 4'hB
`define CAK_NIB_W 4

// Transfer lengths to the card
`define CAK_AUTH1_ARGS 7'h06
`define CAK_AUTH1_LAST 4'h5
`define CAK_AUTH2_LAST 4'h7

// Reset values
`define CAK_CNT_ZERO 4'h0
`define CAK_BYTE_ZERO 8'h00
`define CAK_KEY_ZERO 48'h0000_0000_0000

`endif

// ---- design/cak_pkg.sv ----
// Types of the card authentication and key sequencer.
// Assumes the constants header is on the include path.
`default_nettype none
`include "cak_consts.svh"

package cak_pkg;

  typedef enum logic [2:0] {
    CAK_IDLE     = 3'b000,
    CAK_KEY_WAIT = 3'b001,
    CAK_KEY_READ = 3'b010,
    CAK_A1_WAIT  = 3'b011,
    CAK_A1_POP   = 3'b100,
    CAK_TX_SEND  = 3'b101,
    CAK_RX_WAIT  = 3'b110
  } cak_state_t;

  typedef struct packed {
    cak_state_t st;
    logic [3:0] cnt;
    logic [`CAK_KEY_BITS-1:0] key;
    logic fmt_bad;
    logic phase2;
    logic auth1_ok;
    logic rd_en;
    logic tx_valid;
    logic [7:0] tx_data;
    logic busy;
    logic done;
    logic key_err;
    logic err;
    logic cipher_active;
    logic cipher_init;
  } cak_regs_t;

endpackage

`default_nettype wire

// ---- design/cak_top.sv ----
// Command sequencer for FIFO key load and two-part card authentication.
// Assumes FIFO head data is visible combinationally and popped by fifo_rd_en;
// the transceive engine and the stream cipher core run on ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "cak_consts.svh"

module cak_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cipher_clr,
  input wire logic cipher_set_req,
  output logic busy,
  output logic cmd_done,
  output logic key_format_error,
  output logic primary_status_err,
  output logic cipher_active_bit,
  // FIFO read side
  input wire logic [6:0] fifo_count,
  input wire logic [7:0] fifo_data,
  output logic fifo_rd_en,
  // Transceive path to the card
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_end,
  input wire logic rx_err,
  // Stream cipher core
  input wire logic [7:0] ciph_tx_data,
  input wire logic ciph_reply_ok,
  output logic cipher_init,
  output logic [`CAK_KEY_BITS-1:0] cipher_key
);

  cak_pkg::cak_regs_t s_reg;
  cak_pkg::cak_regs_t s_next;
  logic nib_bad;
  logic reply_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.rd_en = 1'b0;
    s_next.done = 1'b0;
    s_next.cipher_init = 1'b0;
    nib_bad = (fifo_data[7:4] != ~fifo_data[3:0]);
    reply_ok = ciph_reply_ok & ~rx_err;
    // Host may only clear; a write of one is ignored
    if (cipher_clr) begin
      s_next.cipher_active = 1'b0;
    end
    case (s_reg.st)
      cak_pkg::CAK_IDLE: begin
        // Commands start only from the host port
        if (cmd_valid) begin
          s_next.cnt = `CAK_CNT_ZERO;
          case (cmd_code)
            `CAK_CMD_FIFO_KEY_LOAD: begin
              s_next.st = cak_pkg::CAK_KEY_WAIT;
              s_next.phase2 = 1'b0;
              s_next.busy = 1'b1;
              s_next.fmt_bad = 1'b0;
              s_next.key_err = 1'b0;
              s_next.err = 1'b0;
            end
            `CAK_CMD_AUTH_ONE: begin
              s_next.st = cak_pkg::CAK_A1_WAIT;
              s_next.busy = 1'b1;
              s_next.phase2 = 1'b0;
              s_next.auth1_ok = 1'b0;
              s_next.err = 1'b0;
              s_next.cipher_init = 1'b1;
            end
            `CAK_CMD_AUTH_TWO: begin
              // No host bytes; cipher core builds the frame
              s_next.st = cak_pkg::CAK_TX_SEND;
              s_next.busy = 1'b1;
              s_next.phase2 = 1'b1;
              s_next.err = 1'b0;
              s_next.tx_valid = 1'b1;
              s_next.tx_data = ciph_tx_data;
            end
            default: begin
              s_next.st = cak_pkg::CAK_IDLE;
            end
          endcase
        end
      end
      cak_pkg::CAK_KEY_WAIT: begin
        // Wait until all twelve key bytes sit in the FIFO
        if (fifo_count >= `CAK_KEY_BYTES) begin
          s_next.st = cak_pkg::CAK_KEY_READ;
          s_next.rd_en = 1'b1;
        end
      end
      cak_pkg::CAK_KEY_READ: begin
        // One nibble per byte, byte 0 lowest; upper nibble is its complement
        s_next.key[{s_reg.cnt, 2'h0} +: `CAK_NIB_W] = fifo_data[3:0];
        s_next.fmt_bad = s_reg.fmt_bad | nib_bad;
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == `CAK_KEY_LAST) begin
          s_next.st = cak_pkg::CAK_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.key_err = s_reg.fmt_bad | nib_bad;
          s_next.err = s_reg.fmt_bad | nib_bad;
        end else begin
          s_next.rd_en = 1'b1;
        end
      end
      cak_pkg::CAK_A1_WAIT: begin
        if (fifo_count >= `CAK_AUTH1_ARGS) begin
          s_next.st = cak_pkg::CAK_A1_POP;
          s_next.rd_en = 1'b1;
        end
      end
      cak_pkg::CAK_A1_POP: begin
        s_next.st = cak_pkg::CAK_TX_SEND;
        s_next.tx_valid = 1'b1;
        s_next.tx_data = fifo_data;
      end
      cak_pkg::CAK_TX_SEND: begin
        if (tx_ready) begin
          s_next.tx_valid = 1'b0;
          s_next.cnt = s_reg.cnt + 4'h1;
          if (s_reg.cnt == (s_reg.phase2 ? `CAK_AUTH2_LAST : `CAK_AUTH1_LAST)) begin
            s_next.st = cak_pkg::CAK_RX_WAIT;
          end else if (s_reg.phase2) begin
            s_next.tx_valid = 1'b1;
            s_next.tx_data = ciph_tx_data;
          end else begin
            s_next.st = cak_pkg::CAK_A1_POP;
            s_next.rd_en = 1'b1;
          end
        end
      end
      cak_pkg::CAK_RX_WAIT: begin
        // Reply bytes go to the cipher core only, never to the host
        if (rx_end) begin
          s_next.st = cak_pkg::CAK_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          if (s_reg.phase2) begin
            // Set by success wins over a host clear
            s_next.cipher_active = reply_ok & s_reg.auth1_ok;
            s_next.auth1_ok = 1'b0;
            s_next.err = ~(reply_ok & s_reg.auth1_ok);
          end else begin
            s_next.auth1_ok = reply_ok;
            s_next.err = ~reply_ok;
          end
        end
      end
      default: begin
        s_next.st = cak_pkg::CAK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg.st <= cak_pkg::CAK_IDLE;
      s_reg.cnt <= `CAK_CNT_ZERO;
      s_reg.key <= `CAK_KEY_ZERO;
      s_reg.fmt_bad <= 1'b0;
      s_reg.phase2 <= 1'b0;
      s_reg.auth1_ok <= 1'b0;
      s_reg.rd_en <= 1'b0;
      s_reg.tx_valid <= 1'b0;
      s_reg.tx_data <= `CAK_BYTE_ZERO;
      s_reg.busy <= 1'b0;
      s_reg.done <= 1'b0;
      s_reg.key_err <= 1'b0;
      s_reg.err <= 1'b0;
      s_reg.cipher_active <= 1'b0;
      s_reg.cipher_init <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign busy = s_reg.busy;
  assign cmd_done = s_reg.done;
  assign key_format_error = s_reg.key_err;
  assign primary_status_err = s_reg.err;
  assign cipher_active_bit = s_reg.cipher_active;
  assign fifo_rd_en = s_reg.rd_en;
  assign tx_valid = s_reg.tx_valid;
  assign tx_data = s_reg.tx_data;
  assign cipher_init = s_reg.cipher_init;
  assign cipher_key = s_reg.key;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  key_pop_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.st == cak_pkg::CAK_KEY_WAIT && fifo_count >= `CAK_KEY_BYTES)
      |=> fifo_rd_en [*8] ##1 fifo_rd_en [*4] ##1 !fifo_rd_en)
    else $error("key load did not pop twelve bytes");

  key_wait_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.st == cak_pkg::CAK_KEY_WAIT && fifo_count < `CAK_KEY_BYTES) |=> !fifo_rd_en)
    else $error("key pop before twelve bytes present");

  key_err_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.st == cak_pkg::CAK_KEY_READ && s_reg.cnt == `CAK_KEY_LAST)
      |=> key_format_error == $past(s_reg.fmt_bad | nib_bad) && cmd_done && !busy)
    else $error("key format error flag wrong at key load end");

  summary_err_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(key_format_error) |-> primary_status_err)
    else $error("key error without summary error");

  no_host_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cipher_active_bit) |-> $past(s_reg.st == cak_pkg::CAK_RX_WAIT && s_reg.phase2 && rx_end))
    else $error("cipher active set outside part two success");

  host_set_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cipher_set_req && !cipher_active_bit && !(s_reg.st == cak_pkg::CAK_RX_WAIT && s_reg.phase2 && rx_end))
      |=> !cipher_active_bit)
    else $error("host write of one set cipher active");

  host_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cipher_clr && !(s_reg.st == cak_pkg::CAK_RX_WAIT && rx_end)) |=> !cipher_active_bit)
    else $error("host clear of cipher active ignored");

  auth2_result_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.st == cak_pkg::CAK_RX_WAIT && s_reg.phase2 && rx_end)
      |=> cipher_active_bit == $past(reply_ok & s_reg.auth1_ok) && primary_status_err == !cipher_active_bit)
    else $error("part two result not reflected in cipher active");

  auth1_init_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.st == cak_pkg::CAK_IDLE && cmd_valid && cmd_code == `CAK_CMD_AUTH_ONE)
      |=> cipher_init && busy ##1 !cipher_init)
    else $error("part one did not pulse cipher init");

  auth2_no_fifo_a: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && s_reg.phase2) |-> !fifo_rd_en)
    else $error("part two read the FIFO");

  tx_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
    else $error("transmit byte dropped before accept");

endmodule

`default_nettype wire

// ---- tb/cak_far_model.sv ----
// Far side model: host FIFO plus the card behind the transceive path.
// Assumes the bench fills the FIFO through push and reads got afterwards.
`timescale 1ns/100ps
`default_nettype none
module cak_far_model (
  // Clock
  input wire logic ref_clk,
  // FIFO read side
  input wire logic fifo_rd_en,
  output var logic [6:0] fifo_count,
  output var logic [7:0] fifo_data,
  // Card side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var logic tx_ready,
  output var logic rx_end
);
  logic [7:0] q[$];
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic ph = 1'b0;
  logic rd;
  logic acc;
  logic [7:0] d;
  int n_exp = 0;
  int wait_c = 0;
  initial begin
    tx_ready = 1'b0;
    rx_end = 1'b0;
    show();
  end
  task automatic show();
    fifo_count = 7'(q.size());
    fifo_data = (q.size() != 0) ? q[0] : (ph ? 8'hA5 : 8'h5A); // Empty head toggles
  endtask
  task automatic push(input logic [7:0] b);
    q.push_back(b);
    show();
  endtask
  always @(posedge ref_clk) begin
    rd = fifo_rd_en;
    acc = tx_valid && tx_ready;
    d = tx_data;
    #1;
    ph = ~ph;
    rx_end = 1'b0;
    if (rd && q.size() != 0) begin
      void'(q.pop_front());
    end
    if (acc) begin
      got.push_back(d);
      if (got.size() == n_exp) begin
        wait_c = 4;
      end
    end
    if (wait_c != 0) begin
      wait_c--;
      rx_end = (wait_c == 0);
    end
    tx_ready = slow ? ~tx_ready : 1'b1;
    show();
  end
endmodule
`default_nettype wire

// ---- tb/cak_top_tb_top.sv ----
// Bench for the key load and authentication sequencer.
// Assumes cak_top and the far side model; cipher core inputs driven here.
`timescale 1ns/100ps
`default_nettype none
`include "cak_consts.svh"
module cak_top_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic cipher_clr = 1'b0;
  logic cipher_set_req = 1'b0;
  logic rx_err = 1'b0;
  logic [7:0] ciph_tx_data = 8'h3C;
  logic ciph_reply_ok = 1'b1;
  logic busy, cmd_done, key_format_error, primary_status_err, cipher_active_bit;
  logic fifo_rd_en, tx_valid, tx_ready, rx_end, cipher_init;
  logic [6:0] fifo_count;
  logic [7:0] fifo_data, tx_data;
  logic [47:0] cipher_key;
  int fails = 0;
  int n_tests = 0;
  localparam logic [47:0] KEY = 48'h1234_5678_9ABC;
  always #2 ref_clk = ~ref_clk;
  cak_top dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cipher_clr(cipher_clr), .cipher_set_req(cipher_set_req), .busy(busy), .cmd_done(cmd_done),
    .key_format_error(key_format_error), .primary_status_err(primary_status_err),
    .cipher_active_bit(cipher_active_bit), .fifo_count(fifo_count), .fifo_data(fifo_data),
    .fifo_rd_en(fifo_rd_en), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_end(rx_end), .rx_err(rx_err), .ciph_tx_data(ciph_tx_data), .ciph_reply_ok(ciph_reply_ok),
    .cipher_init(cipher_init), .cipher_key(cipher_key));
  cak_far_model far (.ref_clk(ref_clk), .fifo_rd_en(fifo_rd_en), .fifo_count(fifo_count),
    .fifo_data(fifo_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_end(rx_end));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic start_cmd(input logic [7:0] code, input int n_card);
    far.got.delete();
    far.n_exp = n_card;
    cmd_code = code;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    chk(busy, 1'b1);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && cmd_done !== 1'b1; i++) tick(1);
    chk(cmd_done, 1'b1);
    chk(busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic key_load(input logic [47:0] k, input int bad_i, input logic bad);
    logic [7:0] b;
    for (int i = 0; i < 12; i++) begin
      b = {~k[4*i +: 4], k[4*i +: 4]};
      if (i == bad_i) b[7] = ~b[7];
      if (i == 5) begin
        start_cmd(`CAK_CMD_FIFO_KEY_LOAD, 0);
        tick(6);
        chk(fifo_count, 7'h05);
      end
      far.push(b);
    end
    wait_done();
    // Last pop lands in the edge that raises done; look one cycle later
    tick(1);
    chk(fifo_count, 7'h00);
    chk(key_format_error, bad);
    chk(primary_status_err, bad);
    if (!bad) chk(cipher_key, k);
  endtask
  task automatic auth_one(input logic [7:0] b0, input logic ok);
    far.slow = 1'b1;
    ciph_reply_ok = ok;
    start_cmd(`CAK_CMD_AUTH_ONE, 6);
    chk(cipher_init, 1'b1);
    for (int i = 0; i < 6; i++) far.push(b0 + 8'(i));
    wait_done();
    chk(far.got.size(), 6);
    for (int i = 0; i < 6; i++) chk(far.got[i], b0 + 8'(i));
    chk(fifo_count, 7'h00);
    chk(primary_status_err, !ok);
    far.slow = 1'b0;
    ciph_reply_ok = 1'b1;
  endtask
  task automatic auth_two(input logic ok, input logic [7:0] d, input logic rx_bad);
    ciph_tx_data = d;
    rx_err = rx_bad;
    start_cmd(`CAK_CMD_AUTH_TWO, 8);
    wait_done();
    chk(far.got.size(), 8);
    for (int i = 0; i < 8; i++) chk(far.got[i], d);
    chk(fifo_count, 7'h00);
    chk(cipher_active_bit, ok);
    chk(primary_status_err, !ok);
    rx_err = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    fails++;
    complete_run();
  end
  initial begin
    tick(12);
    rst = 1'b0;
    chk(cipher_active_bit, 1'b0);
    chk(busy, 1'b0);
    cipher_set_req = 1'b1;
    tick(2);
    cipher_set_req = 1'b0;
    chk(cipher_active_bit, 1'b0);
    key_load(KEY, 99, 1'b0);
    auth_one(8'h60, 1'b1);
    auth_two(1'b1, 8'h3C, 1'b0);
    auth_two(1'b0, 8'h5A, 1'b0);
    auth_one(8'h61, 1'b0);
    auth_two(1'b0, 8'hC3, 1'b0);
    auth_one(8'h62, 1'b1);
    auth_two(1'b1, 8'h96, 1'b0);
    auth_one(8'h63, 1'b1);
    auth_two(1'b0, 8'h69, 1'b1);
    auth_one(8'h64, 1'b1);
    auth_two(1'b1, 8'h3C, 1'b0);
    cipher_clr = 1'b1;
    tick(1);
    cipher_clr = 1'b0;
    chk(cipher_active_bit, 1'b0);
    key_load(KEY, 7, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
